// ==== src/iwd_decoder.v ====
// Functional notes
// RULE1: Normal word splits into opcode, skip selector, source selector, index select, offset.
// RULE2: Opcode is a six-bit, two-octal-digit operation code.
// RULE3: Skip selector means skip, register, repeat or jump depending on opcode.
// RULE4: Normal format for all opcodes except extended and input/output ones.
// RULE5: Read class loads a register from storage; store class writes register or storage.
// RULE6: Replace class reads storage, operates, writes result to same location.
// RULE7: Source selector offers half-word operands, zero-filled or sign-filled.
// RULE8: Index select 1 to 7 adds that index register to the offset.
// RULE9: Index select zero adds zero, offset alone is the address.
// RULE10: Read class: 0,4 immediate; 1,2,3,5,6 storage; 7 accumulator.
// RULE11: Offset and index are added as unsigned values.
// RULE12: Addition uses end-around carry back into the lowest bit.
// RULE13: Fifteen-bit index configuration makes every addition 15 bits wide.
// RULE14: Dual-index configuration uses 17 bits for index 4 to 7, else 15.
// RULE15: All-zero sum only when offset and index contribution are both zero.
// RULE16: No-operation variant starts nothing and only inserts a delay.
// RULE17: Opcode octal 77 takes bits 23-18 as the actual operation.
// RULE18: Extended format ignores class for sourcing; index and offset work normally.
// RULE19: I/O modifier may be 0 or 1 for send opcodes, otherwise 0.
// RULE20: Fields come combinationally from the registered word in the same cycle.
`timescale 1ns/1ps
`include "iwd_defines.vh"

module iwd_decoder (
   // Clock and reset
   input wire clock,
   input wire reset,
   // Instruction handoff from fetch
   input wire instr_load,
   input wire [`IWD_WORD_W-1:0] instr_word,
   input wire [1:0] instr_class,
   output wire instr_ready,
   // Configuration and index registers B1..B7, 17 bits each, B1 lowest
   input wire internal_function_register_dual_index,
   input wire [7*`IWD_ADDR_W-1:0] index_file,
   // Operand sources
   input wire [`IWD_WORD_W-1:0] accumulator,
   input wire [`IWD_WORD_W-1:0] storage_rdata,
   input wire storage_ready,
   // Execution handshake
   input wire exec_done,
   input wire [`IWD_WORD_W-1:0] exec_result,
   // Decoded fields
   output wire [5:0] opcode,
   output wire [2:0] skip_sel,
   output wire [2:0] src_sel,
   output wire [2:0] index_sel,
   output wire [`IWD_HALF_W-1:0] offset,
   output wire [5:0] actual_op,
   output wire is_extended,
   output wire is_io,
   output wire [3:0] io_modifier,
   output wire [1:0] io_src_sel,
   output wire io_send_function,
   output wire io_modifier_error,
   output wire [1:0] skip_kind,
   output wire is_nop,
   output wire is_illegal,
   output wire wide_add,
   output wire [`IWD_ADDR_W-1:0] effective,
   output wire effective_zero,
   // Operand source decode
   output wire use_immediate,
   output wire use_storage,
   output wire use_accumulator,
   output wire halfword,
   output wire sign_fill,
   // Sequencer
   output wire storage_read_req,
   output wire storage_write_req,
   output reg [`IWD_ADDR_W-1:0] storage_addr_q,
   output reg [`IWD_WORD_W-1:0] storage_wdata_q,
   output reg [`IWD_WORD_W-1:0] operand_q,
   output wire exec_start,
   output reg step_done_q,
   output wire busy
);

   // ==========================================
   // Sequencer states
   localparam ST_IDLE = 3'h0;
   localparam ST_FETCH = 3'h1;
   localparam ST_EXEC = 3'h2;
   localparam ST_WRITE = 3'h3;
   localparam ST_DELAY = 3'h4;
   localparam ST_DONE = 3'h5;

   // ==========================================
   // Decode helpers
   function is_io_op;
      input [5:0] op;
      begin
         case (op)
            `IWD_OP_IO13, `IWD_OP_IO17, `IWD_OP_IO62, `IWD_OP_IO63, `IWD_OP_IO66,
            `IWD_OP_IO67, `IWD_OP_IO73, `IWD_OP_IO74, `IWD_OP_IO75, `IWD_OP_IO76: is_io_op = 1'b1;
            default: is_io_op = 1'b0;
         endcase
      end
   endfunction

   function [1:0] kind_of;
      input [5:0] op;
      begin
         case (op)
            `IWD_OP_REG12, `IWD_OP_REG72, `IWD_OP_REG16, `IWD_OP_REG71: kind_of = `IWD_JK_REG;
            `IWD_OP_REP70: kind_of = `IWD_JK_REPEAT;
            `IWD_OP_JMP60, `IWD_OP_JMP61, `IWD_OP_JMP64, `IWD_OP_JMP65: kind_of = `IWD_JK_JUMP;
            default: kind_of = `IWD_JK_SKIP;
         endcase
      end
   endfunction

   // Only the two send opcodes may carry a nonzero modifier
   function is_send_op;
      input [5:0] op;
      begin
         case (op)
            `IWD_OP_IO74, `IWD_OP_IO76: is_send_op = 1'b1;
            default: is_send_op = 1'b0;
         endcase
      end
   endfunction

   // Selector decode is shared by immediate, storage and accumulator paths
   function [1:0] src_kind;
      input [2:0] sel;
      begin
         case (sel)
            3'h0, 3'h4: src_kind = 2'h0;
            3'h7: src_kind = 2'h2;
            default: src_kind = 2'h1;
         endcase
      end
   endfunction

   function [`IWD_WORD_W-1:0] fill_half;
      input [`IWD_HALF_W-1:0] half;
      input sfill;
      begin
         fill_half = {{`IWD_HALF_W{sfill & half[`IWD_HALF_W-1]}}, half};
      end
   endfunction

   // ==========================================
   // Registered instruction word
   reg [`IWD_WORD_W-1:0] instr_q;
   reg [1:0] class_q;
   reg pend_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [3:0] delay_q;

   assign instr_ready = (state_q == ST_IDLE) && !pend_q;

   always @(posedge clock) begin
      if (reset) begin
         instr_q <= {`IWD_WORD_W{1'b0}};
         class_q <= `IWD_CLASS_NONE;
         pend_q <= 1'b0;
      end else if (instr_load && instr_ready) begin
         instr_q <= instr_word;
         class_q <= instr_class;
         pend_q <= 1'b1;
      end else if (state_q == ST_IDLE && pend_q) begin
         pend_q <= 1'b0;
      end
   end

   // ==========================================
   // Field extraction, same cycle as the registered word [RULE20]
   assign opcode = instr_q[`IWD_OP_HI:`IWD_OP_LO]; // [RULE1] [RULE2]
   assign skip_sel = instr_q[`IWD_SKIP_HI:`IWD_SKIP_LO]; // [RULE1]
   assign src_sel = instr_q[`IWD_SRC_HI:`IWD_SRC_LO]; // [RULE1]
   assign index_sel = instr_q[`IWD_IDX_HI:`IWD_IDX_LO]; // [RULE1]
   assign offset = instr_q[`IWD_OFS_HI:`IWD_OFS_LO]; // [RULE1]

   assign is_extended = (opcode == `IWD_OP_EXT); // [RULE4]
   assign is_io = is_io_op(opcode); // [RULE4]
   // Extended word carries its real operation in place of skip and source fields
   wire [5:0] ext_op;
   assign ext_op = instr_q[`IWD_EXT_HI:`IWD_EXT_LO];
   assign actual_op = is_extended ? ext_op : opcode; // [RULE17]

   assign io_modifier = is_io ? instr_q[`IWD_IOMOD_HI:`IWD_IOMOD_LO] : 4'h0;
   assign io_src_sel = is_io ? instr_q[`IWD_IOSRC_HI:`IWD_IOSRC_LO] : 2'h0;
   // Send opcodes accept 0 (data) or 1 (function word); every other I/O opcode only 0
   assign io_send_function = is_io && is_send_op(opcode) && (io_modifier == 4'h1); // [RULE19]
   assign io_modifier_error = is_io && (is_send_op(opcode) ? (io_modifier > 4'h1) :
      (io_modifier != 4'h0)); // [RULE19]

   // Skip selector meaning only exists in the normal format
   assign skip_kind = (is_extended || is_io) ? `IWD_JK_SKIP : kind_of(opcode); // [RULE3]
   assign is_nop = (opcode == `IWD_OP_REG12 || opcode == `IWD_OP_REG72) && (skip_sel == 3'h0); // [RULE16]
   assign is_illegal = (opcode == `IWD_OP_ZERO) ||
      (is_extended && ext_op == 6'h00);

   // ==========================================
   // Index selection and address adder
   wire [`IWD_ADDR_W-1:0] index_value;
   wire [`IWD_ADDR_W-1:0] index_slot [0:7];

   assign index_slot[0] = {`IWD_ADDR_W{1'b0}}; // [RULE9]
   genvar gi;
   generate
      for (gi = 1; gi < 8; gi = gi + 1) begin : g_index
         assign index_slot[gi] = index_file[gi*`IWD_ADDR_W-1:(gi-1)*`IWD_ADDR_W]; // [RULE8]
      end
   endgenerate
   assign index_value = index_slot[index_sel]; // [RULE8]

   // Upper four index registers get the wide adder only in the dual configuration
   assign wide_add = internal_function_register_dual_index && index_sel[2]; // [RULE13] [RULE14]

   iwd_eac_adder u_adder (
      .offset(offset),
      .index_value(index_value),
      .wide(wide_add),
      .sum(effective)
   );
   assign effective_zero = (effective == {`IWD_ADDR_W{1'b0}}); // [RULE15]

   // ==========================================
   // Operand source decode
   wire normal_fmt;
   wire [1:0] skind;
   wire is_read;
   wire is_store;
   wire is_replace;
   wire store_to_mem;

   assign normal_fmt = !is_extended && !is_io;
   assign skind = src_kind(src_sel);
   assign is_read = normal_fmt && class_q == `IWD_CLASS_READ;
   assign is_store = normal_fmt && class_q == `IWD_CLASS_STORE;
   assign is_replace = normal_fmt && class_q == `IWD_CLASS_REPLACE;
   // Class plays no part in the extended format [RULE18]
   assign use_immediate = is_read && skind == 2'h0; // [RULE10]
   assign use_storage = (is_read || is_replace) && skind == 2'h1; // [RULE5] [RULE6] [RULE10]
   assign use_accumulator = is_read && skind == 2'h2; // [RULE10]
   assign store_to_mem = is_store && skind == 2'h1; // [RULE5]

   // Selector 3 moves the whole word; 1,5 low half and 2,6 high half; 4..6 sign-fill
   reg half_sel;
   reg sfill_sel;

   always @* begin
      half_sel = 1'b0;
      sfill_sel = 1'b0;
      case (src_sel)
         3'h1, 3'h2: begin
            half_sel = 1'b1;
         end
         3'h4: begin
            sfill_sel = 1'b1;
         end
         3'h5, 3'h6: begin
            half_sel = 1'b1;
            sfill_sel = 1'b1;
         end
         default: begin
            half_sel = 1'b0;
            sfill_sel = 1'b0;
         end
      endcase
   end
   assign halfword = normal_fmt && half_sel; // [RULE7]
   assign sign_fill = normal_fmt && sfill_sel; // [RULE7]

   wire [`IWD_WORD_W-1:0] storage_operand;
   wire [`IWD_WORD_W-1:0] direct_operand;

   assign storage_operand = !halfword ? storage_rdata :
      fill_half(src_sel[1] ? storage_rdata[`IWD_WORD_W-1:`IWD_HALF_W] : storage_rdata[`IWD_HALF_W-1:0],
      sign_fill); // [RULE7]
   // Immediate value is the low 15 bits of the sum unless the wide adder was used
   assign direct_operand = use_accumulator ? accumulator :
      (wide_add ? {{(`IWD_WORD_W-`IWD_ADDR_W){1'b0}}, effective} :
      fill_half(effective[`IWD_HALF_W-1:0], sign_fill)); // [RULE10]

   // ==========================================
   // Sequencer: fetch, execute, write back
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (pend_q) begin
               if (is_illegal)
                  state_d = ST_DONE;
               else if (is_nop)
                  state_d = ST_DELAY; // [RULE16]
               else if (use_storage)
                  state_d = ST_FETCH; // [RULE5] [RULE6]
               else
                  state_d = ST_EXEC;
            end
         end
         ST_FETCH: begin
            if (storage_ready)
               state_d = ST_EXEC;
         end
         ST_EXEC: begin
            if (exec_done)
               state_d = (is_replace || store_to_mem) ? ST_WRITE : ST_DONE; // [RULE6]
         end
         ST_WRITE: begin
            if (storage_ready)
               state_d = ST_DONE;
         end
         ST_DELAY: begin
            if (delay_q == `IWD_NOP_DELAY)
               state_d = ST_DONE;
         end
         ST_DONE: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge clock) begin
      if (reset) begin
         state_q <= ST_IDLE;
         delay_q <= 4'h0;
         storage_addr_q <= {`IWD_ADDR_W{1'b0}};
         storage_wdata_q <= {`IWD_WORD_W{1'b0}};
         operand_q <= {`IWD_WORD_W{1'b0}};
         step_done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         step_done_q <= (state_d == ST_DONE);
         delay_q <= (state_q == ST_DELAY) ? delay_q + 4'h1 : 4'h0;
         // Address is captured once so the write-back lands on the word that was read
         if (state_q == ST_IDLE && pend_q)
            storage_addr_q <= effective; // [RULE6]
         if (state_q == ST_IDLE && pend_q && !use_storage)
            operand_q <= direct_operand; // [RULE10] [RULE18]
         if (state_q == ST_FETCH && storage_ready)
            operand_q <= storage_operand; // [RULE5] [RULE7]
         if (state_q == ST_EXEC && exec_done)
            storage_wdata_q <= exec_result; // [RULE6]
      end
   end

   // No-operation never raises a storage or execution request [RULE16]
   assign storage_read_req = (state_q == ST_FETCH);
   assign storage_write_req = (state_q == ST_WRITE);
   assign exec_start = (state_q == ST_EXEC);
   assign busy = (state_q != ST_IDLE) || pend_q;

endmodule // iwd_decoder

// ==== common/iwd_defines.vh ====
`ifndef IWD_DEFINES_VH
`define IWD_DEFINES_VH

// ==========================================
// Word and field layout
`define IWD_WORD_W 30
`define IWD_HALF_W 15
`define IWD_ADDR_W 17
`define IWD_OP_HI 29
`define IWD_OP_LO 24
`define IWD_SKIP_HI 23
`define IWD_SKIP_LO 21
`define IWD_SRC_HI 20
`define IWD_SRC_LO 18
`define IWD_IDX_HI 17
`define IWD_IDX_LO 15
`define IWD_OFS_HI 14
`define IWD_OFS_LO 0
`define IWD_EXT_HI 23
`define IWD_EXT_LO 18
`define IWD_IOMOD_HI 23
`define IWD_IOMOD_LO 20
`define IWD_IOSRC_HI 19
`define IWD_IOSRC_LO 18

// ==========================================
// Opcodes (octal value in the name)
`define IWD_OP_ZERO 6'h00
`define IWD_OP_EXT 6'h3F
`define IWD_OP_REG12 6'h0A
`define IWD_OP_REG72 6'h3A
`define IWD_OP_REG16 6'h0E
`define IWD_OP_REG71 6'h39
`define IWD_OP_REP70 6'h38
`define IWD_OP_JMP60 6'h30
`define IWD_OP_JMP61 6'h31
`define IWD_OP_JMP64 6'h34
`define IWD_OP_JMP65 6'h35
`define IWD_OP_IO13 6'h0B
`define IWD_OP_IO17 6'h0F
`define IWD_OP_IO62 6'h32
`define IWD_OP_IO63 6'h33
`define IWD_OP_IO66 6'h36
`define IWD_OP_IO67 6'h37
`define IWD_OP_IO73 6'h3B
`define IWD_OP_IO74 6'h3C
`define IWD_OP_IO75 6'h3D
`define IWD_OP_IO76 6'h3E

// ==========================================
// Instruction class, selector kinds, sequencer timing
`define IWD_CLASS_NONE 2'h0
`define IWD_CLASS_READ 2'h1
`define IWD_CLASS_STORE 2'h2
`define IWD_CLASS_REPLACE 2'h3
`define IWD_JK_SKIP 2'h0
`define IWD_JK_REG 2'h1
`define IWD_JK_REPEAT 2'h2
`define IWD_JK_JUMP 2'h3
`define IWD_NOP_DELAY 4'h1

`endif

// ==== src/iwd_eac_adder.v ====
`timescale 1ns/1ps
`include "iwd_defines.vh"

// ==========================================
// Unsigned end-around-carry adder, 15 or 17 bits wide
module iwd_eac_adder (
   // Operands
   input wire [`IWD_HALF_W-1:0] offset,
   input wire [`IWD_ADDR_W-1:0] index_value,
   input wire wide,
   // Result
   output wire [`IWD_ADDR_W-1:0] sum
);
   wire [`IWD_HALF_W:0] raw15;
   wire [`IWD_ADDR_W:0] raw17;
   wire [`IWD_HALF_W-1:0] sum15;
   wire [`IWD_ADDR_W-1:0] sum17;

   // Both inputs zero-extended, never sign-extended [RULE11]
   assign raw15 = {1'b0, offset} + {1'b0, index_value[`IWD_HALF_W-1:0]};
   assign raw17 = {3'h0, offset} + {1'b0, index_value};
   // Carry re-enters at bit 0; a second carry is impossible since the first sum is at most 2^(n+1)-2 [RULE12]
   assign sum15 = raw15[`IWD_HALF_W-1:0] + {{(`IWD_HALF_W-1){1'b0}}, raw15[`IWD_HALF_W]};
   assign sum17 = raw17[`IWD_ADDR_W-1:0] + {{(`IWD_ADDR_W-1){1'b0}}, raw17[`IWD_ADDR_W]};
   // Result is zero only for zero plus zero; all ones stays as minus zero [RULE15]
   assign sum = wide ? sum17 : {2'h0, sum15}; // [RULE13] [RULE14]

endmodule // iwd_eac_adder

// ==== tb/iwd_exec_model.sv ====
`timescale 1ns/1ps
// ====================
// Storage and execution units facing the decoder
module iwd_exec_model #(
   parameter logic [29:0] MEM = 30'h1234C321,
   parameter logic [29:0] RES = 30'h0ABCDE5F
) (
   // Clock, reset, pacing
   input wire clock,
   input wire reset,
   input wire [1:0] dly,
   // Requests
   input wire storage_read_req,
   input wire storage_write_req,
   input wire exec_start,
   // Answers
   output logic storage_ready,
   output logic [29:0] storage_rdata,
   output logic exec_done,
   output logic [29:0] exec_result
);
   logic [1:0] wait_q;
   // Inverted outside the ack cycle, so a late sample never matches
   assign storage_rdata = storage_ready ? MEM : ~MEM;
   assign exec_result = exec_done ? RES : ~RES;
   always @(posedge clock) begin
      storage_ready <= 1'b0;
      exec_done <= 1'b0;
      if (reset) begin
         wait_q <= 2'h0;
      end else begin
         if ((storage_read_req || storage_write_req) && !storage_ready) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == dly) begin
               storage_ready <= 1'b1;
               wait_q <= 2'h0;
            end
         end
         exec_done <= exec_start && !exec_done;
      end
   end
endmodule // iwd_exec_model

// ==== tb/iwd_decoder_monitor.sv ====
`timescale 1ns/1ps
// ====================
// Port checks of the decoder
module iwd_decoder_monitor (
   // Handoff
   input wire clock,
   input wire reset,
   input wire instr_load,
   input wire instr_ready,
   input wire [29:0] instr_word,
   input wire internal_function_register_dual_index,
   input wire [118:0] index_file,
   // Decode
   input wire [5:0] opcode,
   input wire [2:0] skip_sel,
   input wire [2:0] src_sel,
   input wire [2:0] index_sel,
   input wire [14:0] offset,
   input wire [5:0] actual_op,
   input wire is_extended,
   input wire is_nop,
   input wire wide_add,
   input wire [16:0] effective,
   // Sequencer
   input wire [29:0] storage_rdata,
   input wire storage_ready,
   input wire storage_read_req,
   input wire storage_write_req,
   input wire exec_start,
   input wire busy,
   input wire [29:0] operand_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // Reference end-around sums; slot 0 of the padded file reads as zero
   wire [135:0] bfile = {index_file, 17'h0};
   wire [16:0] bval = bfile[index_sel*17 +: 17];
   wire [15:0] r15 = {1'b0, offset} + {1'b0, bval[14:0]};
   wire [17:0] r17 = {3'h0, offset} + {1'b0, bval};
   property p_fld; instr_load && instr_ready |=> {opcode, skip_sel, src_sel, index_sel, offset} == $past(instr_word);
   endproperty
   a_fld: assert property (p_fld) else $error("fields");
   property p_ext; is_extended |-> opcode == 6'h3F && actual_op == {skip_sel, src_sel}; endproperty
   a_ext: assert property (p_ext) else $error("ext op");
   property p_b0; index_sel == 3'h0 |-> effective == {2'h0, offset}; endproperty
   a_b0: assert property (p_b0) else $error("index zero");
   property p_wide; wide_add == (internal_function_register_dual_index && index_sel[2]); endproperty
   a_wide: assert property (p_wide) else $error("width");
   property p_narrow; !wide_add |-> effective == {2'h0, r15[14:0] + {14'h0, r15[15]}}; endproperty
   a_narrow: assert property (p_narrow) else $error("narrow");
   property p_wsum; wide_add |-> effective == r17[16:0] + {16'h0, r17[17]}; endproperty
   a_wsum: assert property (p_wsum) else $error("wide sum");
   property p_hold; storage_read_req && !storage_ready |=> storage_read_req; endproperty
   a_hold: assert property (p_hold) else $error("read drop");
   property p_opnd; storage_read_req && storage_ready && src_sel == 3'h3 |=>
      operand_q == $past(storage_rdata) && exec_start; endproperty
   a_opnd: assert property (p_opnd) else $error("operand");
   property p_nop; is_nop && busy |-> !storage_read_req && !storage_write_req && !exec_start; endproperty
   a_nop: assert property (p_nop) else $error("nop");
endmodule // iwd_decoder_monitor

bind iwd_decoder iwd_decoder_monitor u_mon (.clock, .reset, .instr_load, .instr_ready, .instr_word,
   .internal_function_register_dual_index, .index_file, .opcode, .skip_sel, .src_sel, .index_sel, .offset, .actual_op,
   .is_extended, .is_nop, .wide_add, .effective, .storage_rdata, .storage_ready, .storage_read_req,
   .storage_write_req, .exec_start, .busy, .operand_q);

// ==== tb/iwd_testbench.sv ====
`timescale 1ns/1ps
// ====================
// Decoder bench
module testbench;
   localparam logic [29:0] MEM = 30'h1234C321;
   localparam logic [29:0] RES = 30'h0ABCDE5F;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic instr_load = 1'b0;
   logic [29:0] instr_word = 30'h0;
   logic [1:0] instr_class = 2'h0;
   logic internal_function_register_dual_index = 1'b0;
   logic [118:0] index_file = {34'h0, 17'h18001, 17'h10005, 17'h07FFF, 17'h0, 17'h1};
   logic [29:0] accumulator = 30'h15A5A5A5;
   logic [1:0] dly = 2'h0;
   wire instr_ready, storage_ready, exec_done, is_extended, is_io, io_send_function, io_modifier_error, is_nop;
   wire is_illegal, wide_add, effective_zero, use_immediate, use_storage, use_accumulator, halfword, sign_fill;
   wire storage_read_req, storage_write_req, exec_start, step_done_q, busy;
   wire [29:0] storage_rdata, exec_result, storage_wdata_q, operand_q;
   wire [16:0] effective, storage_addr_q;
   wire [14:0] offset;
   wire [5:0] opcode, actual_op;
   wire [3:0] io_modifier;
   wire [2:0] skip_sel, src_sel, index_sel;
   wire [1:0] io_src_sel, skip_kind;
   wire [4:0] src_dec = {use_immediate, use_storage, use_accumulator, halfword, sign_fill};
   wire [29:0] io_dec = {21'h0, is_io, io_modifier, io_src_sel, io_send_function, io_modifier_error};
   integer num_errors = 0;
   integer n_tests = 0;
   integer i;
   logic s;
   logic [29:0] seq, xo, wd, wa;
   // Dual flag, index select, offset, expected sum
   logic [35:0] ta [0:8] = '{{4'h1, 15'h7FFF, 17'h1}, {4'hD, 15'h7FFF, 17'h1}, {4'h4, 15'h3, 17'h8},
      {4'hC, 15'h3, 17'h10008}, {4'hB, 15'h3, 17'h3}, {4'h0, 15'h1234, 17'h1234}, {4'h2, 15'h0, 17'h0},
      {4'h0, 15'h0, 17'h0}, {4'h3, 15'h0, 17'h7FFF}};
   logic [29:0] tk [0:7] = '{30'h4000, 30'h4321, 30'h2469, MEM, 30'h3FFFC000, 30'h3FFFC321, 30'h2469, 30'h15A5A5A5};
   logic [5:0] ot [0:13] = '{6'h08, 6'h0A, 6'h38, 6'h30, 6'h0B, 6'h0F, 6'h32, 6'h33, 6'h36, 6'h37, 6'h3B, 6'h3C,
      6'h3D, 6'h3E};
   // Per selector: immediate, storage, accumulator, half-word, sign-fill
   logic [4:0] sk [0:7] = '{5'h10, 5'h0A, 5'h0A, 5'h08, 5'h11, 5'h0B, 5'h0B, 5'h04};
   iwd_decoder uut (.clock, .reset, .instr_load, .instr_word, .instr_class, .instr_ready,
      .internal_function_register_dual_index, .index_file, .accumulator, .storage_rdata, .storage_ready, .exec_done,
      .exec_result, .opcode, .skip_sel, .src_sel, .index_sel, .offset, .actual_op, .is_extended, .is_io,
      .io_modifier, .io_src_sel, .io_send_function, .io_modifier_error, .skip_kind, .is_nop, .is_illegal,
      .wide_add, .effective, .effective_zero, .use_immediate, .use_storage, .use_accumulator, .halfword,
      .sign_fill, .storage_read_req, .storage_write_req, .storage_addr_q, .storage_wdata_q, .operand_q,
      .exec_start, .step_done_q, .busy);
   iwd_exec_model #(.MEM(MEM), .RES(RES)) env (.clock, .reset, .dly, .storage_read_req, .storage_write_req,
      .exec_start, .storage_ready, .storage_rdata, .exec_done, .exec_result);
   task ck(input string nm, input logic [29:0] e, input logic [29:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task run(input logic [29:0] w, input logic [1:0] c, input logic d);
      @(posedge clock);
      instr_load <= 1'b1;
      instr_word <= w;
      instr_class <= c;
      internal_function_register_dual_index <= d;
      @(posedge clock);
      instr_load <= 1'b0;
      #1;
   endtask
   // Records request order as digits: 1 read, 2 execute, 3 write
   task fin;
      integer n;
      logic [29:0] ev;
      seq = 30'h0;
      for (n = 0; n < 40 && step_done_q !== 1'b1; n++) begin
         ev = storage_read_req === 1'b1 ? 30'h1 : exec_start === 1'b1 ? 30'h2 :
            storage_write_req === 1'b1 ? 30'h3 : 30'h0;
         if (ev != 30'h0 && ev != {26'h0, seq[3:0]}) seq = {seq[25:0], ev[3:0]};
         if (exec_start === 1'b1) xo = operand_q;
         if (storage_write_req === 1'b1) wa = {13'h0, storage_addr_q};
         if (storage_write_req === 1'b1) wd = storage_wdata_q;
         @(posedge clock);
         #1;
      end
      ck("done", 30'h1, {29'h0, step_done_q});
   endtask
   task close_out;
      if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial forever #10 clock = ~clock;
   initial begin
      #100000;
      num_errors++;
      close_out;
   end
   initial begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      for (i = 0; i < 9; i++) begin
         run({6'h08, 3'h5, 3'h0, ta[i][34:17]}, 2'h1, ta[i][35]);
         ck("fields", {12'h228, ta[i][34:17]}, {opcode, skip_sel, src_sel, index_sel, offset});
         ck("sum", {13'h0, ta[i][16:0]}, {13'h0, effective});
         ck("zero", {29'h0, ta[i][16:0] == 17'h0}, {29'h0, effective_zero});
         fin;
         ck("operand", {13'h0, ta[i][16:0]}, xo);
      end
      for (i = 0; i < 8; i++) begin
         dly <= i[1:0];
         run({6'h08, 3'h0, i[2:0], 18'h04000}, 2'h1, 1'b0);
         ck("source", {25'h0, sk[i]}, {25'h0, src_dec});
         fin;
         ck("order", (i % 4 == 0 || i == 7) ? 30'h2 : 30'h12, seq);
         ck("operand", tk[i], xo);
      end
      for (i = 3; i > 1; i--) begin
         run({6'h08, 3'h0, 3'h3, 3'h1, 15'h0010}, i[1:0], 1'b0);
         fin;
         ck("order", i == 3 ? 30'h123 : 30'h23, seq);
         ck("address", 30'h11, wa);
         ck("data", RES, wd);
      end
      run({6'h3F, 6'h15, 3'h4, 15'h0003}, 2'h1, 1'b1);
      ck("ext", {6'h0, 1'b1, 6'h15, 17'h10008}, {6'h0, is_extended, actual_op, effective});
      fin;
      ck("order", 30'h2, seq);
      run({6'h0A, 24'h0}, 2'h1, 1'b0);
      ck("nop", 30'h2, {28'h0, is_nop, is_illegal});
      fin;
      ck("order", 30'h0, seq);
      run({6'h3F, 24'h0}, 2'h1, 1'b0);
      ck("illegal", 30'h1, {29'h0, is_illegal});
      fin;
      ck("order", 30'h0, seq);
      for (i = 0; i < 14; i++) begin
         s = ot[i] == 6'h3C || ot[i] == 6'h3E;
         run({ot[i], 4'h1, 2'h2, 18'h0}, 2'h0, 1'b0);
         if (i < 4) ck("skip", {28'h0, i[1:0]}, {28'h0, skip_kind});
         else ck("io", {21'h0, 5'h11, 2'h2, s, !s}, io_dec);
         fin;
      end
      close_out;
   end
endmodule // testbench
